//--- verilog/fbh_pkg.sv
package fbh_pkg;

   // -----------------------------------------------------------------
   // Geometry
   // -----------------------------------------------------------------
   localparam int unsigned FBH_ADDR_W      = 21;
   localparam int unsigned FBH_DATA_W      = 16;
   localparam int unsigned FBH_BLK_LSB     = 16;
   localparam int unsigned FBH_BLK_W       = 5;
   localparam int unsigned FBH_BLK_LAST    = 31;
   localparam logic [20:0] FBH_ADDR_LAST   = 21'h1FFFFF;
   localparam logic [20:0] FBH_BLK_SIZE    = 21'h010000;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int unsigned FBH_CLK_PS      = 4000;
   localparam int unsigned FBH_PD_MIN_NS   = 100;
   localparam int unsigned FBH_PD_CYC      = (FBH_PD_MIN_NS * 1000 + FBH_CLK_PS - 1) / FBH_CLK_PS;
   localparam int unsigned FBH_RD_CYC      = 4;
   localparam int unsigned FBH_WR_CYC      = 4;
   localparam int unsigned FBH_SU_CYC      = 1;
   localparam int unsigned FBH_WAKE_CYC    = 8;

   // -----------------------------------------------------------------
   // Read-mode commands, written before a read
   // -----------------------------------------------------------------
   localparam logic [15:0] FBH_CMD_READ_ARRAY = 16'h00FF;
   localparam logic [15:0] FBH_CMD_READ_ID    = 16'h0090;
   localparam logic [15:0] FBH_CMD_QUERY      = 16'h0098;
   localparam logic [15:0] FBH_CMD_READ_STAT  = 16'h0070;

   typedef enum logic [1:0] {
      FBH_MODE_ARRAY = 2'h0,
      FBH_MODE_ID    = 2'h1,
      FBH_MODE_QUERY = 2'h2,
      FBH_MODE_STAT  = 2'h3
   } fbh_mode_e;

   typedef enum logic [7:0] {
      FBH_ST_PD    = 8'h01,
      FBH_ST_WAKE  = 8'h02,
      FBH_ST_IDLE  = 8'h04,
      FBH_ST_WSU   = 8'h08,
      FBH_ST_WPUL  = 8'h10,
      FBH_ST_WHLD  = 8'h20,
      FBH_ST_RD    = 8'h40,
      FBH_ST_RDONE = 8'h80
   } fbh_state_e;

endpackage

//--- verilog/fbh_sync.sv
`timescale 1ns/1ps
module fbh_sync #(
   parameter int unsigned W = 16
) (
   // Clock and reset
   input  wire logic         clk_sys,
   input  wire logic         resetn,
   // Data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s1_nxt;
   logic [W-1:0] q_r;
   logic [W-1:0] q_nxt;

   always_comb begin
      s1_nxt = d;
      q_nxt  = s1_r;
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         s1_r <= '0;
         q_r  <= '0;
      end else begin
         s1_r <= s1_nxt;
         q_r  <= q_nxt;
      end
   end

   assign q = q_r;
endmodule

//--- verilog/fbh_host.sv
// Behaviour
// - Host writes the matching read-mode command before a read with req_mode_set whose mode is not already in force.
// - Host drives bank selects and output enable active together to read.
// - Host keeps write strobe and reset pin high during reads.
// - All bus cycles follow ordinary asynchronous processor bus conventions.
// - Host holds reset pin low at least 100 ns for deep power-down.
`timescale 1ns/1ps
module fbh_host
   import fbh_pkg::*;
#(
   parameter int unsigned ADDR_W = FBH_ADDR_W,
   parameter int unsigned DATA_W = FBH_DATA_W
) (
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              resetn,
   // User request
   input  wire logic              req_valid,
   output logic                   req_ready,
   input  wire logic              req_write,
   input  wire logic              req_bank,
   input  wire logic [ADDR_W-1:0] req_addr,
   input  wire logic [DATA_W-1:0] req_wdata,
   input  wire logic              req_mode_set,
   input  wire fbh_mode_e         req_mode,
   output logic                   rsp_valid,
   output logic [DATA_W-1:0]      rsp_rdata,
   output logic [FBH_BLK_W-1:0]   rsp_block,
   // Power and protection control
   input  wire logic              pd_req,
   input  wire logic              wp_allow,
   output logic                   pd_active,
   // Flash pins
   output logic                   reset_powerdown_n,
   output logic                   shared_select_n,
   output logic                   low_bank_select_n,
   output logic                   high_bank_select_n,
   output logic                   oe_n,
   output logic                   we_n,
   output logic                   wp_n,
   output logic [ADDR_W-1:0]      addr,
   input  wire logic [DATA_W-1:0] data_pins_i,
   output logic [DATA_W-1:0]      data_pins_o,
   output logic                   data_pins_oe
);

   // ----------------------------------------------------------------
   // Pin input synchroniser
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] din_s;

   fbh_sync #(.W(DATA_W)) u_sync (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .d       (data_pins_i),
      .q       (din_s)
   );

   // ----------------------------------------------------------------
   // Bus state
   // ----------------------------------------------------------------
   fbh_state_e        st_r,     st_nxt;
   logic [7:0]        cnt_r,    cnt_nxt;
   logic              bank_r,   bank_nxt;
   logic              sel_r,    sel_nxt;
   logic              oe_r,     oe_nxt;
   logic              we_r,     we_nxt;
   logic              drv_r,    drv_nxt;
   logic              rstp_r,   rstp_nxt;
   logic              rdcmd_r,  rdcmd_nxt;
   logic              moded_r,  moded_nxt;
   fbh_mode_e         mode_r,   mode_nxt;
   fbh_mode_e         pmode_r,  pmode_nxt;
   logic [ADDR_W-1:0] addr_r,   addr_nxt;
   logic [DATA_W-1:0] wd_r,     wd_nxt;
   logic [DATA_W-1:0] rd_r,     rd_nxt;
   logic              rv_r,     rv_nxt;
   logic              pwr_r,    pwr_nxt;

   function automatic logic [DATA_W-1:0] mode_cmd(input fbh_mode_e m);
      case (m)
         FBH_MODE_ID:    mode_cmd = FBH_CMD_READ_ID;
         FBH_MODE_QUERY: mode_cmd = FBH_CMD_QUERY;
         FBH_MODE_STAT:  mode_cmd = FBH_CMD_READ_STAT;
         default:        mode_cmd = FBH_CMD_READ_ARRAY;
      endcase
   endfunction

   always_comb begin
      st_nxt    = st_r;
      cnt_nxt   = cnt_r;
      bank_nxt  = bank_r;
      sel_nxt   = sel_r;
      oe_nxt    = 1'b0;
      we_nxt    = 1'b0;
      drv_nxt   = drv_r;
      rstp_nxt  = rstp_r;
      rdcmd_nxt = rdcmd_r;
      moded_nxt = moded_r;
      mode_nxt  = mode_r;
      pmode_nxt = pmode_r;
      addr_nxt  = addr_r;
      wd_nxt    = wd_r;
      rd_nxt    = rd_r;
      rv_nxt    = 1'b0;
      pwr_nxt   = pwr_r;
      case (st_r)
         FBH_ST_PD: begin
            rstp_nxt = 1'b0;
            sel_nxt  = 1'b0;
            drv_nxt  = 1'b0;
            if (cnt_r < 8'(FBH_PD_CYC)) begin
               cnt_nxt = cnt_r + 8'h01;
            end else if (!pd_req) begin
               rstp_nxt = 1'b1;
               cnt_nxt  = 8'h00;
               st_nxt   = FBH_ST_WAKE;
            end
         end
         FBH_ST_WAKE: begin
            // The device comes back in array mode by itself.
            mode_nxt  = FBH_MODE_ARRAY;
            moded_nxt = 1'b1;
            if (cnt_r < 8'(FBH_WAKE_CYC)) begin
               cnt_nxt = cnt_r + 8'h01;
            end else begin
               st_nxt = FBH_ST_IDLE;
            end
         end
         FBH_ST_IDLE: begin
            sel_nxt = 1'b0;
            drv_nxt = 1'b0;
            cnt_nxt = 8'h00;
            if (pd_req) begin
               st_nxt = FBH_ST_PD;
            end else if (req_valid) begin
               bank_nxt  = req_bank;
               addr_nxt  = req_addr;
               pwr_nxt   = req_write;
               pmode_nxt = req_mode;
               // A read with req_mode_set in a mode other than the current one first writes that mode's command.
               if (req_mode_set && !req_write && !(moded_r && mode_r == req_mode)) begin
                  rdcmd_nxt = 1'b1;
                  wd_nxt    = mode_cmd(req_mode);
                  st_nxt    = FBH_ST_WSU;
               end else if (req_write) begin
                  wd_nxt = req_wdata;
                  st_nxt = FBH_ST_WSU;
               end else begin
                  st_nxt = FBH_ST_RD;
               end
            end
         end
         FBH_ST_WSU: begin
            sel_nxt = 1'b1;
            drv_nxt = 1'b1;
            if (cnt_r < 8'(FBH_SU_CYC)) begin
               cnt_nxt = cnt_r + 8'h01;
            end else begin
               cnt_nxt = 8'h00;
               we_nxt  = 1'b1;
               st_nxt  = FBH_ST_WPUL;
            end
         end
         FBH_ST_WPUL: begin
            we_nxt = 1'b1;
            if (cnt_r < 8'(FBH_WR_CYC)) begin
               cnt_nxt = cnt_r + 8'h01;
            end else begin
               // Strobe rises before select so the latch edge is the strobe's.
               we_nxt  = 1'b0;
               cnt_nxt = 8'h00;
               st_nxt  = FBH_ST_WHLD;
            end
         end
         FBH_ST_WHLD: begin
            // Select and data stay one cycle past the strobe's rise, so the strobe edge latches.
            sel_nxt = 1'b0;
            drv_nxt = 1'b0;
            if (rdcmd_r) begin
               rdcmd_nxt = 1'b0;
               mode_nxt  = pmode_r;
               moded_nxt = 1'b1;
               st_nxt    = pwr_r ? FBH_ST_IDLE : FBH_ST_RD;
            end else begin
               if (wd_r == FBH_CMD_READ_ARRAY) begin
                  mode_nxt  = FBH_MODE_ARRAY;
                  moded_nxt = 1'b1;
               end else begin
                  moded_nxt = 1'b0;
               end
               rv_nxt = 1'b1;
               st_nxt = FBH_ST_IDLE;
            end
         end
         FBH_ST_RD: begin
            // Write strobe stays high and selects plus output enable go low together.
            sel_nxt = 1'b1;
            oe_nxt  = 1'b1;
            drv_nxt = 1'b0;
            if (cnt_r < 8'(FBH_RD_CYC)) begin
               cnt_nxt = cnt_r + 8'h01;
            end else begin
               rd_nxt = din_s;
               st_nxt = FBH_ST_RDONE;
            end
         end
         FBH_ST_RDONE: begin
            // Output enable and selects drop together; the device then floats its pins.
            oe_nxt   = 1'b0;
            sel_nxt  = 1'b0;
            rv_nxt   = 1'b1;
            cnt_nxt  = 8'h00;
            st_nxt   = FBH_ST_IDLE;
         end
         default: begin
            st_nxt = FBH_ST_PD;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         st_r    <= FBH_ST_PD;
         cnt_r   <= 8'h00;
         bank_r  <= 1'b0;
         sel_r   <= 1'b0;
         oe_r    <= 1'b0;
         we_r    <= 1'b0;
         drv_r   <= 1'b0;
         rstp_r  <= 1'b0;
         rdcmd_r <= 1'b0;
         moded_r <= 1'b0;
         mode_r  <= FBH_MODE_ARRAY;
         pmode_r <= FBH_MODE_ARRAY;
         addr_r  <= '0;
         wd_r    <= '0;
         rd_r    <= '0;
         rv_r    <= 1'b0;
         pwr_r   <= 1'b0;
      end else begin
         st_r    <= st_nxt;
         cnt_r   <= cnt_nxt;
         bank_r  <= bank_nxt;
         sel_r   <= sel_nxt;
         oe_r    <= oe_nxt;
         we_r    <= we_nxt;
         drv_r   <= drv_nxt;
         rstp_r  <= rstp_nxt;
         rdcmd_r <= rdcmd_nxt;
         moded_r <= moded_nxt;
         mode_r  <= mode_nxt;
         pmode_r <= pmode_nxt;
         addr_r  <= addr_nxt;
         wd_r    <= wd_nxt;
         rd_r    <= rd_nxt;
         rv_r    <= rv_nxt;
         pwr_r   <= pwr_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Pin drive
   // ----------------------------------------------------------------
   // Shared select plus low select picks the first bank, plus high select the second.
   assign shared_select_n    = ~sel_r;
   assign low_bank_select_n  = ~(sel_r & ~bank_r);
   assign high_bank_select_n = ~(sel_r & bank_r);
   assign oe_n               = ~oe_r;
   assign we_n               = ~we_r;
   assign reset_powerdown_n  = rstp_r;
   assign wp_n               = wp_allow;
   assign addr               = addr_r;
   assign data_pins_o        = wd_r;
   assign data_pins_oe       = drv_r;
   assign pd_active          = (st_r == FBH_ST_PD);
   assign req_ready          = (st_r == FBH_ST_IDLE) && !pd_req;
   assign rsp_valid          = rv_r;
   assign rsp_rdata          = rd_r;
   assign rsp_block          = addr_r[FBH_BLK_LSB +: FBH_BLK_W];

endmodule

//--- sim/fbh_flash_model.sv
`timescale 1ns/1ps
module fbh_flash_model #(
   parameter int unsigned DLY      = 5,
   parameter logic [15:0] ID_WORD  = 16'h00C3,
   parameter logic [15:0] QRY_WORD = 16'h0011
) (
   // Control pins
   input  wire logic        reset_powerdown_n,
   input  wire logic        shared_select_n,
   input  wire logic        low_bank_select_n,
   input  wire logic        high_bank_select_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic        wp_n,
   // Address and data
   input  wire logic [20:0] addr,
   input  wire logic [15:0] dq_in,
   output logic      [15:0] dq_o,
   output logic             dq_oe
);
   // ---------------------------------------------------------------
   // Device behaviour
   // ---------------------------------------------------------------
   // The id and query words are arbitrary values.
   logic [1:0] mode = 2'h0;
   wire first_bank = !shared_select_n && !low_bank_select_n;
   wire second_bank = !shared_select_n && !high_bank_select_n;
   wire sel = reset_powerdown_n && (first_bank || second_bank);
   wire wr_act = sel && !we_n;
   // Output turn-on lags by DLY so the host's sample point is exercised.
   assign #(DLY) dq_oe = sel && !oe_n && we_n;
   // The array is read-only, so no write, erase or lock path can alter it.
   always_comb begin
      case (mode)
         2'h1: dq_o = ID_WORD;
         2'h2: dq_o = QRY_WORD;
         2'h3: dq_o = 16'h0080;
         default: dq_o = addr[15:0] ^ {addr[20:16], 11'h000} ^ (second_bank ? 16'h5A5A : 16'h0000);
      endcase
   end
   always @(negedge wr_act or negedge reset_powerdown_n) begin
      if (!reset_powerdown_n) begin
         mode <= 2'h0;
      end else begin
         case (dq_in[7:0])
            8'hFF: mode <= 2'h0;
            8'h90: mode <= 2'h1;
            8'h98: mode <= 2'h2;
            8'h70: mode <= 2'h3;
            default: mode <= mode;
         endcase
      end
   end
endmodule

//--- sim/fbh_host_properties.sv
`timescale 1ns/1ps
module fbh_host_properties
   import fbh_pkg::*;
#(
   parameter int unsigned ADDR_W = FBH_ADDR_W,
   parameter int unsigned DATA_W = FBH_DATA_W
) (
   // Clock and reset
   input wire logic              clk_sys,
   input wire logic              resetn,
   // Watched ports
   input wire logic              rsp_valid,
   input wire logic              reset_powerdown_n,
   input wire logic              shared_select_n,
   input wire logic              low_bank_select_n,
   input wire logic              high_bank_select_n,
   input wire logic              oe_n,
   input wire logic              we_n,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] data_pins_o,
   input wire logic              data_pins_oe
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   // Saturating count of low reset-pin cycles, so a long power-down cannot wrap.
   logic [7:0] low_cnt_r;
   logic [7:0] low_cnt_nxt;
   always_comb begin
      low_cnt_nxt = low_cnt_r;
      if (reset_powerdown_n)
         low_cnt_nxt = 8'h00;
      else if (low_cnt_r != 8'hFF)
         low_cnt_nxt = low_cnt_r + 8'h01;
   end
   always_ff @(posedge clk_sys) begin
      if (!resetn)
         low_cnt_r <= 8'h00;
      else
         low_cnt_r <= low_cnt_nxt;
   end
   rd_one_bank_a: assert property (!oe_n |-> !shared_select_n && (low_bank_select_n ^ high_bank_select_n))
      else $error("read without exactly one bank selected");
   rd_quiet_a: assert property (!oe_n |-> we_n && reset_powerdown_n && !data_pins_oe)
      else $error("read with strobe, reset or host drive active");
   wr_setup_a: assert property ($fell(we_n) |-> !$past(shared_select_n) && data_pins_oe && oe_n)
      else $error("write strobe without prior select and data");
   wr_hold_a: assert property (!we_n && !$past(we_n) |-> $stable(addr) && $stable(data_pins_o))
      else $error("address or data moved during write strobe");
   wr_first_rise_a: assert property ($rose(we_n) |-> !shared_select_n && data_pins_oe)
      else $error("select or data released before write strobe");
   rd_hold_a: assert property (!oe_n && !$past(oe_n) |-> $stable(addr) && $stable(low_bank_select_n))
      else $error("address or bank moved during read");
   rd_end_a: assert property ($rose(oe_n) |-> rsp_valid)
      else $error("read ended without response");
   pd_low_time_a: assert property ($rose(reset_powerdown_n) |-> low_cnt_r >= 8'(FBH_PD_CYC))
      else $error("reset pin low pulse too short");
   pd_no_cycle_a: assert property (!reset_powerdown_n |-> oe_n && we_n)
      else $error("bus cycle while reset pin low");
endmodule
bind fbh_host fbh_host_properties #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_props (
   .clk_sys, .resetn, .rsp_valid, .reset_powerdown_n, .shared_select_n, .low_bank_select_n,
   .high_bank_select_n, .oe_n, .we_n, .addr, .data_pins_o, .data_pins_oe
);

//--- sim/test_flash_bus_read_protect.sv
`timescale 1ns/1ps
module test_flash_bus_read_protect
   import fbh_pkg::*;
;
   // Arbitrary id and query words for the model.
   localparam logic [15:0] TB_ID  = 16'h00C3;
   localparam logic [15:0] TB_QRY = 16'h0011;
   logic        clk_sys, resetn, req_valid, req_ready, req_write, req_bank, req_mode_set;
   logic        rsp_valid, pd_req, wp_allow, pd_active, wp_n, data_pins_oe, dev_oe;
   logic        reset_powerdown_n, shared_select_n, low_bank_select_n, high_bank_select_n, oe_n, we_n;
   fbh_mode_e   req_mode;
   logic [20:0] req_addr, addr;
   logic [15:0] req_wdata, rsp_rdata, data_pins_o, dev_o;
   logic [15:0] bus_last = 16'h0000;
   logic [4:0]  rsp_block;
   wire  [15:0] data_pins_i;
   int          mismatches = 0, checked = 0, cycles = 0;
   // An undriven bus shows the inverse of its last value rather than a lucky match.
   assign data_pins_i = data_pins_oe ? data_pins_o : (dev_oe ? dev_o : ~bus_last);
   fbh_host uut (
      .clk_sys, .resetn, .req_valid, .req_ready, .req_write, .req_bank, .req_addr, .req_wdata,
      .req_mode_set, .req_mode, .rsp_valid, .rsp_rdata, .rsp_block, .pd_req, .wp_allow, .pd_active,
      .reset_powerdown_n, .shared_select_n, .low_bank_select_n, .high_bank_select_n, .oe_n, .we_n,
      .wp_n, .addr, .data_pins_i, .data_pins_o, .data_pins_oe
   );
   fbh_flash_model #(.DLY(5), .ID_WORD(TB_ID), .QRY_WORD(TB_QRY)) model (
      .reset_powerdown_n, .shared_select_n, .low_bank_select_n, .high_bank_select_n, .oe_n, .we_n,
      .wp_n, .addr, .dq_in(data_pins_i), .dq_o(dev_o), .dq_oe(dev_oe)
   );
   // ---------------------------------------------------------------
   // Clock, watchdog and shared tasks
   // ---------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      if (data_pins_oe || dev_oe)
         bus_last <= data_pins_i;
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         mismatches++;
         finish_test();
      end
   end
   task automatic finish_test();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic cmp(input string name, input logic [31:0] want, input logic [31:0] got);
      checked++;
      if (got !== want) begin
         mismatches++;
         $display("BAD %s expected %0h seen %0h", name, want, got);
      end
   endtask
   function automatic logic [15:0] array_word(input logic bank, input logic [20:0] a);
      return a[15:0] ^ {a[20:16], 11'h000} ^ (bank ? 16'h5A5A : 16'h0000);
   endfunction
   task automatic access(input logic wr, input logic bank, input logic [20:0] a, input logic [15:0] wd,
                         input logic ms, input fbh_mode_e m, output logic [15:0] rd);
      int n;
      n = 0;
      while (req_ready !== 1'b1 && n < 200) begin
         @(negedge clk_sys);
         n++;
      end
      req_valid = 1'b1;
      req_write = wr;
      req_bank = bank;
      req_addr = a;
      req_wdata = wd;
      req_mode_set = ms;
      req_mode = m;
      @(negedge clk_sys);
      req_valid = 1'b0;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 60) begin
         @(negedge clk_sys);
         n++;
      end
      cmp("rsp_valid", 1, rsp_valid);
      cmp("rsp_block", a[20:16], rsp_block);
      rd = rsp_rdata;
      @(negedge clk_sys);
      cmp("dev_oe", 0, dev_oe);
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_banks();
      logic [15:0] rd;
      logic [20:0] a [4] = '{21'h000000, 21'h00FFFE, 21'h010000, 21'h1FFFFE};
      for (int b = 0; b < 2; b++) begin
         for (int i = 0; i < 4; i++) begin
            access(1'b0, b[0], a[i], 16'h0000, 1'b0, FBH_MODE_ARRAY, rd);
            cmp("array_word", array_word(b[0], a[i]), rd);
         end
      end
      $display("test banks done");
   endtask
   task automatic t_modes();
      logic [15:0] rd;
      logic [15:0] want [4] = '{array_word(1'b1, 21'h0A0004), TB_ID, TB_QRY, 16'h0080};
      for (int m = 3; m >= 0; m--) begin
         access(1'b0, 1'b1, 21'h0A0004, 16'h0000, 1'b1, fbh_mode_e'(m), rd);
         cmp("mode_word", want[m], rd);
      end
      $display("test modes done");
   endtask
   task automatic t_cmd_write();
      logic [15:0] rd;
      access(1'b1, 1'b0, 21'h030000, FBH_CMD_READ_ARRAY, 1'b0, FBH_MODE_ARRAY, rd);
      access(1'b0, 1'b0, 21'h030000, 16'h0000, 1'b1, FBH_MODE_ARRAY, rd);
      cmp("array_word", array_word(1'b0, 21'h030000), rd);
      access(1'b1, 1'b0, 21'h030000, FBH_CMD_READ_STAT, 1'b0, FBH_MODE_ARRAY, rd);
      access(1'b0, 1'b0, 21'h030000, 16'h0000, 1'b0, FBH_MODE_ARRAY, rd);
      cmp("status_word", 16'h0080, rd);
      $display("test command write done");
   endtask
   task automatic t_powerdown();
      logic [15:0] rd;
      int low;
      low = 0;
      pd_req = 1'b1;
      repeat (40) begin
         @(negedge clk_sys);
         if (reset_powerdown_n === 1'b0)
            low++;
      end
      cmp("pd_active", 1, pd_active);
      cmp("pd_low_long", 1, low >= FBH_PD_CYC);
      cmp("pd_ready", 0, req_ready);
      pd_req = 1'b0;
      access(1'b0, 1'b1, 21'h1F0002, 16'h0000, 1'b0, FBH_MODE_ARRAY, rd);
      cmp("wake_array", array_word(1'b1, 21'h1F0002), rd);
      $display("test powerdown done");
   endtask
   task automatic t_protect();
      for (int v = 0; v < 2; v++) begin
         wp_allow = v[0];
         @(negedge clk_sys);
         cmp("wp_n", v[0], wp_n);
      end
      $display("test protect done");
   endtask
   task automatic t_reset();
      logic [15:0] rd;
      @(negedge clk_sys);
      resetn = 1'b0;
      repeat (2) @(negedge clk_sys);
      cmp("rst_pin", 0, reset_powerdown_n);
      cmp("rst_pd", 1, pd_active);
      cmp("rst_rsp", 0, rsp_valid);
      resetn = 1'b1;
      access(1'b0, 1'b0, 21'h000010, 16'h0000, 1'b1, FBH_MODE_ARRAY, rd);
      cmp("rst_array", array_word(1'b0, 21'h000010), rd);
      $display("test reset done");
   endtask
   initial begin
      resetn = 1'b0;
      req_valid = 1'b0;
      req_write = 1'b0;
      req_bank = 1'b0;
      req_addr = 21'h000000;
      req_wdata = 16'h0000;
      req_mode_set = 1'b0;
      req_mode = FBH_MODE_ARRAY;
      pd_req = 1'b0;
      wp_allow = 1'b0;
      repeat (8) @(negedge clk_sys);
      resetn = 1'b1;
      t_banks();
      t_modes();
      t_cmd_write();
      t_powerdown();
      t_protect();
      t_reset();
      finish_test();
   end
endmodule
